// *** verilog/dhap_pkg.sv ***
package dhap_pkg;
  // system-bus port offsets inside the four-port block
  localparam logic [1:0] PORT_DATA = 2'h0;     // data in/out
  localparam logic [1:0] PORT_CTRL = 2'h1;     // control, write only
  localparam logic [1:0] PORT_STAT = 2'h2;     // status, read only
  // control port field positions
  localparam int CTRL_SEL_BIT = 6;             // select with data bit 0
  localparam int CTRL_DEN_BIT = 1;             // data enable after selection
  // status port field positions
  localparam int STAT_REQ_BIT  = 7;
  localparam int STAT_IO_BIT   = 6;
  localparam int STAT_MSG_BIT  = 5;
  localparam int STAT_CD_BIT   = 4;
  localparam int STAT_BUSY_BIT = 3;
  localparam logic [2:0] STAT_LOW_FILL = 3'h3; // unused bits: 2 low, 1..0 high
  // descriptor and reply lengths
  localparam int CDB_SHORT_LEN = 6;
  localparam int CDB_LONG_LEN  = 10;
  localparam int SYNDROME_LEN  = 2;
  localparam int SENSE_LEN     = 4;
  // acknowledge pulse length in clocks
  localparam int ACK_CYCLES    = 2;
  // controller-side register offsets (designer's own)
  localparam logic [1:0] CREG_CMD  = 2'h0;     // write: start phase
  localparam logic [1:0] CREG_DATA = 2'h1;     // write: byte to send / read: byte received
  localparam logic [1:0] CREG_STAT = 2'h2;     // read: phase status
  // controller phase codes written to CREG_CMD bits 1..0
  localparam logic [1:0] PH_DATA_IN  = 2'h0;   // controller to adapter data
  localparam logic [1:0] PH_DATA_OUT = 2'h1;   // adapter to controller data
  localparam logic [1:0] PH_CMD      = 2'h2;   // descriptor bytes to controller
  localparam logic [1:0] PH_STATUS   = 2'h3;   // status byte to adapter
endpackage

// *** verilog/dhap_if.sv ***
`timescale 1ns/1ps
`default_nettype none
// logical levels of the active-low controller bus, one wire per signal
interface dhap_if;
  logic       sel_n;      // select, from adapter
  logic       ack_n;      // acknowledge, from adapter
  logic       busy_n;     // busy, from controller
  logic       req_n;      // request, from controller
  logic       io_n;       // low: controller drives data
  logic       cd_n;       // low: command or status phase
  logic       msg_n;      // low: last byte
  logic [7:0] ad_do_n;    // adapter data drive value
  logic       ad_oe;      // adapter drives data
  logic [7:0] ct_do_n;    // controller data drive value
  logic       ct_oe;      // controller drives data
  logic [7:0] data_n;     // resolved bus, idle high
  assign data_n = (ad_oe ? ad_do_n : 8'hff) & (ct_oe ? ct_do_n : 8'hff);
  modport adapter (output sel_n, output ack_n, output ad_do_n, output ad_oe,
                   input busy_n, input req_n, input io_n, input cd_n, input msg_n, input data_n);
  modport controller (input sel_n, input ack_n, input data_n,
                      output busy_n, output req_n, output io_n, output cd_n, output msg_n,
                      output ct_do_n, output ct_oe);
endinterface
`default_nettype wire

// *** verilog/dhap_adapter.sv ***
// Operation
// - no parity bit generated on controller bus
// - descriptor byte 0 holds class and opcode
// - controller seeks and verifies on access
// - short descriptor is six ascending bytes
// - long descriptor is ten ascending bytes
// - syndrome reply is exactly two bytes
// - sense reply is exactly four bytes
// - bytes move in ascending order, byte 0 first
// - all controller bus lines active low
// - slave clear resets adapter state
// - bus clock never treated as synchronous
// - output/input status lines split writes, reads
// - address valid only with status-valid strobe
// - decode write and read qualifiers exactly
// - control bit 6 selects, bit 1 enables data
// - status bits 7..3 report controller lines
// - acknowledge pulse after each byte cycle
//
// The implementer's own choices: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module dhap_adapter #(
  parameter logic [5:0] BASE_ADDR = 6'h00     // upper six I/O address bits
) (
  input  wire logic       clk_i,
  input  wire logic       resetn_i,           // power-on reset
  input  wire logic       slave_clr_n_i,      // system slave clear, pin
  input  wire logic       pstval_n_i,         // status-valid strobe, pin
  input  wire logic       sout_i,             // output cycle status, pin
  input  wire logic       sinp_i,             // input cycle status, pin
  input  wire logic       pwr_n_i,            // write low, pin
  input  wire logic       pdbin_i,            // data in request, pin
  input  wire logic [7:0] addr_i,             // I/O address, pin
  input  wire logic [7:0] dout_i,             // processor write data, pin
  output logic      [7:0] din_o,              // processor read data
  output logic            din_oe_o,           // drive read data
  dhap_if.adapter         cbus
);
  initial begin
    if (BASE_ADDR > 6'h3f) $error("bad base");
  end
  // two-flop synchronisers, none of stage one feeds logic
  typedef struct packed {
    logic [7:0] a1, a2;          // address sync
    logic [7:0] d1, d2;          // write data sync
    logic [5:0] s1, s2;          // {pstval_n, sout, sinp, pwr_n, pdbin, clr_n}
    logic [3:0] c1, c2;          // {busy_n, req_n, io_n, cd_n}
    logic       m1, m2;          // msg_n
    logic [7:0] b1, b2;          // controller data
    logic       stb_d;           // synced strobe one clock back, for its falling edge
    logic       valid;           // cycle qualified by strobe
    logic [7:0] lat_addr;        // address caught at strobe
    logic       lat_out, lat_inp;
    logic       wr_done, rd_done;// one access per cycle
    logic       sel;             // select asserted
    logic       den;             // data enabled
    logic [7:0] hold;            // holding register
    logic       hold_full;       // byte waiting for ack
    logic [1:0] ack_cnt;         // acknowledge counter
    logic [7:0] din;
    logic       din_oe;
  } dhap_ad_t;
  dhap_ad_t st_r, st_nxt;
  logic [7:0] stat_v;

  // port decode used by both read and write
  function automatic logic hit(input logic [7:0] a, input logic [1:0] p);
    hit = (a[7:2] == BASE_ADDR) && (a[1:0] == p);
  endfunction

  always_comb begin
    st_nxt = st_r;
    stat_v = 8'h00;
    st_nxt.a1 = addr_i;  st_nxt.a2 = st_r.a1;
    st_nxt.d1 = dout_i;  st_nxt.d2 = st_r.d1;
    st_nxt.s1 = {pstval_n_i, sout_i, sinp_i, pwr_n_i, pdbin_i, slave_clr_n_i};
    st_nxt.s2 = st_r.s1;
    st_nxt.c1 = {cbus.busy_n, cbus.req_n, cbus.io_n, cbus.cd_n};
    st_nxt.c2 = st_r.c1;
    st_nxt.m1 = cbus.msg_n;
    st_nxt.m2 = st_r.m1;
    st_nxt.b1 = cbus.data_n;
    st_nxt.b2 = st_r.b1;
    // status from active-low lines, unused bits fixed
    stat_v[dhap_pkg::STAT_REQ_BIT]  = ~st_r.c2[2];
    stat_v[dhap_pkg::STAT_IO_BIT]   = st_r.c2[1];   // high: data to controller
    stat_v[dhap_pkg::STAT_MSG_BIT]  = ~st_r.m2;
    stat_v[dhap_pkg::STAT_CD_BIT]   = ~st_r.c2[0];
    stat_v[dhap_pkg::STAT_BUSY_BIT] = ~st_r.c2[3];
    stat_v[2:0] = dhap_pkg::STAT_LOW_FILL;
    // strobe catches stable address and status, once per falling edge only,
    // so a long strobe cannot re-arm the write and send a held byte twice
    st_nxt.stb_d = st_r.s2[5];
    if (!st_r.s2[5] && st_r.stb_d) begin
      st_nxt.valid    = 1'b1;
      st_nxt.lat_addr = st_r.a2;
      st_nxt.lat_out  = st_r.s2[4];
      st_nxt.lat_inp  = st_r.s2[3];
      st_nxt.wr_done  = 1'b0;
      st_nxt.rd_done  = 1'b0;
    end
    // write: output cycle with write line low
    if (st_r.valid && st_r.lat_out && !st_r.s2[2] && !st_r.wr_done) begin
      st_nxt.wr_done = 1'b1;
      if (hit(st_r.lat_addr, dhap_pkg::PORT_CTRL)) begin
        st_nxt.sel = st_r.d2[dhap_pkg::CTRL_SEL_BIT];
        st_nxt.den = st_r.d2[dhap_pkg::CTRL_DEN_BIT];
      end else if (hit(st_r.lat_addr, dhap_pkg::PORT_DATA)) begin
        st_nxt.hold      = st_r.d2;
        st_nxt.hold_full = 1'b1;
      end
    end
    // read: data-in, write line high, input status
    st_nxt.din_oe = 1'b0;
    if (st_r.valid && st_r.lat_inp && st_r.s2[1] && st_r.s2[2]) begin
      if (hit(st_r.lat_addr, dhap_pkg::PORT_STAT)) begin
        st_nxt.din_oe = 1'b1;
        st_nxt.din    = stat_v;
      end else if (hit(st_r.lat_addr, dhap_pkg::PORT_DATA)) begin
        st_nxt.din_oe = 1'b1;
        st_nxt.din    = ~st_r.b2;
        st_nxt.rd_done = 1'b1;
      end
    end
    // read finished: acknowledge the byte taken
    if (st_r.rd_done && !(st_r.s2[1]) && st_r.ack_cnt == 2'h0 && !st_r.c2[2]) begin
      st_nxt.rd_done = 1'b0;
      st_nxt.valid   = 1'b0;
      st_nxt.ack_cnt = 2'(dhap_pkg::ACK_CYCLES);
    end
    // held byte meets its request (outbound only)
    if (st_r.hold_full && !st_r.c2[2] && st_r.c2[1] && st_r.ack_cnt == 2'h0) begin
      st_nxt.hold_full = 1'b0;
      st_nxt.ack_cnt   = 2'(dhap_pkg::ACK_CYCLES);
    end
    if (st_r.ack_cnt != 2'h0) begin
      st_nxt.ack_cnt = st_r.ack_cnt - 2'h1;
    end
    // slave clear resets select, data enable, held-byte flag, ack counter and cycle valid
    if (!st_r.s2[0]) begin
      st_nxt.sel       = 1'b0;
      st_nxt.den       = 1'b0;
      st_nxt.hold_full = 1'b0;
      st_nxt.ack_cnt   = 2'h0;
      st_nxt.valid     = 1'b0;
      st_nxt.din_oe    = 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st_r <= '0;
      st_r.s1 <= 6'h3f;  // idle: strobe high, clear released
      st_r.s2 <= 6'h3f;
      st_r.stb_d <= 1'b1;
      st_r.c1 <= 4'hf;
      st_r.c2 <= 4'hf;
      st_r.m1 <= 1'b1;
      st_r.m2 <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  // controller lines, active low; no parity line exists
  always_comb begin
    cbus.sel_n   = ~st_r.sel;
    cbus.ack_n   = ~(st_r.ack_cnt != 2'h0);
    cbus.ad_do_n = st_r.sel && !st_r.den ? 8'hfe : ~st_r.hold;
    cbus.ad_oe   = st_r.sel || (st_r.den && st_r.c2[1]);
  end
  assign din_o    = st_r.din;
  assign din_oe_o = st_r.din_oe;
endmodule
`default_nettype wire

// *** verilog/dhap_controller.sv ***
// controller end: host presents phases through simple registers
`timescale 1ns/1ps
`default_nettype none
module dhap_controller (
  input  wire logic       clk_i,
  input  wire logic       resetn_i,
  input  wire logic [1:0] addr_i,    // register index
  input  wire logic [7:0] wdata_i,
  input  wire logic       wr_i,
  input  wire logic       rd_i,
  output logic      [7:0] rdata_o,   // valid cycle after rd_i
  dhap_if.controller      cbus
);
  typedef enum logic [1:0] {C_IDLE, C_REQ, C_ACK} dhap_cph_t;
  typedef struct packed {
    logic [2:0] sy1, sy2;   // {sel_n, ack_n, data0_n}
    logic [7:0] bd1, bd2;
    dhap_cph_t  ph;
    logic       busy;
    logic [1:0] mode;       // current phase code
    logic       last;       // mark final byte
    logic [7:0] tx, rx;
    logic       rx_new;     // byte arrived, sticky
    logic [7:0] rdata;
  } dhap_ct_t;
  dhap_ct_t st_r, st_nxt;
  logic outb;

  always_comb begin
    st_nxt = st_r;
    outb = (st_r.mode == dhap_pkg::PH_DATA_OUT) || (st_r.mode == dhap_pkg::PH_CMD);
    st_nxt.sy1 = {cbus.sel_n, cbus.ack_n, cbus.data_n[0]};
    st_nxt.sy2 = st_r.sy1;
    st_nxt.bd1 = cbus.data_n;
    st_nxt.bd2 = st_r.bd1;
    // selection with data bit 0 grants busy
    if (!st_r.busy && !st_r.sy2[2] && !st_r.sy2[0]) st_nxt.busy = 1'b1;
    unique case (st_r.ph)
      C_IDLE: ;
      C_REQ: if (!st_r.sy2[1]) begin
        if (outb) st_nxt.rx = ~st_r.bd2;
        st_nxt.rx_new = 1'b1;
        st_nxt.ph = C_ACK;
      end
      C_ACK: if (st_r.sy2[1]) begin
        st_nxt.ph = C_IDLE;
        // host marks the final byte of each counted string
        if (st_r.last && st_r.mode == dhap_pkg::PH_STATUS) st_nxt.busy = 1'b0;
      end
    endcase
    st_nxt.rdata = 8'h00;
    if (rd_i) begin
      unique case (addr_i)
        dhap_pkg::CREG_DATA: st_nxt.rdata = st_r.rx;
        dhap_pkg::CREG_STAT: st_nxt.rdata = {4'h0, st_r.rx_new, st_r.ph == C_IDLE, st_r.busy, st_r.last};
        default: st_nxt.rdata = 8'h00;
      endcase
      if (addr_i == dhap_pkg::CREG_DATA) st_nxt.rx_new = 1'b0;
    end
    if (st_r.ph == C_REQ && !st_r.sy2[1]) st_nxt.rx_new = 1'b1;  // set wins over clear
    if (wr_i && st_r.busy && st_r.ph == C_IDLE) begin
      if (addr_i == dhap_pkg::CREG_CMD) begin
        st_nxt.mode = wdata_i[1:0];
        st_nxt.last = wdata_i[2];
      end else if (addr_i == dhap_pkg::CREG_DATA) begin
        st_nxt.tx = wdata_i;
        st_nxt.ph = C_REQ;
      end
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st_r <= '0;
      st_r.sy1 <= 3'h7;
      st_r.sy2 <= 3'h7;
    end else begin
      st_r <= st_nxt;
    end
  end

  always_comb begin
    cbus.busy_n  = ~st_r.busy;
    cbus.req_n   = ~(st_r.ph == C_REQ);
    cbus.io_n    = (st_r.mode == dhap_pkg::PH_DATA_OUT) || (st_r.mode == dhap_pkg::PH_CMD);
    cbus.cd_n    = ~((st_r.mode == dhap_pkg::PH_CMD) || (st_r.mode == dhap_pkg::PH_STATUS));
    cbus.msg_n   = ~st_r.last;
    cbus.ct_do_n = ~st_r.tx;
    cbus.ct_oe   = st_r.busy && !outb && st_r.ph != C_IDLE;
  end
  assign rdata_o = st_r.rdata;
endmodule
`default_nettype wire

// *** testbench/dhap_asserts.sv ***
`timescale 1ns/1ps
`default_nettype none
// watches the controller bus between the two ends
module dhap_asserts (
  input wire logic       clk_i,
  input wire logic       resetn_i,
  input wire logic       sel_n,
  input wire logic       ack_n,
  input wire logic       busy_n,
  input wire logic       req_n,
  input wire logic       io_n,
  input wire logic       ad_oe,
  input wire logic       ct_oe,
  input wire logic [7:0] ad_do_n,
  input wire logic [7:0] data_n
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  // ack is low for exactly two clocks
  property p_ack_len; $fell(ack_n) |=> !ack_n ##1 ack_n; endproperty
  a_ack_len: assert property (p_ack_len) else $error("ack pulse length wrong");
  // ack only answers a pending request of a busy controller
  property p_ack_req; $fell(ack_n) |-> !req_n && !busy_n; endproperty
  a_ack_req: assert property (p_ack_req) else $error("ack without request");
  // select goes out with data bit 0 asserted
  property p_sel_data0; (!sel_n && busy_n) |-> ad_oe && !data_n[0]; endproperty
  a_sel_data0: assert property (p_sel_data0) else $error("select without data bit 0");
  // two cycles of grace at a turnaround, then no fight on the data lines
  property p_contend; ct_oe && $past(ct_oe, 2) |-> !ad_oe; endproperty
  a_contend: assert property (p_contend) else $error("both ends drive data");
  // outbound byte presented and steady across its ack
  property p_hold; $fell(ack_n) && io_n |-> ad_oe ##1 (ad_oe && $stable(ad_do_n)); endproperty
  a_hold: assert property (p_hold) else $error("held byte not presented");
  // inbound byte: adapter keeps off the lines
  property p_in_free; $fell(ack_n) && !io_n |-> !ad_oe; endproperty
  a_in_free: assert property (p_in_free) else $error("adapter drives inbound byte");
  // released reset leaves select and ack idle
  property p_rst; $rose(resetn_i) |-> sel_n && ack_n; endproperty
  a_rst: assert property (p_rst) else $error("lines not idle after reset");
  // transfers only after selection is over
  property p_sel_free; $fell(ack_n) |-> sel_n; endproperty
  a_sel_free: assert property (p_sel_free) else $error("ack during selection");
  c_out: cover property ($fell(ack_n) && io_n);
  c_in: cover property ($fell(ack_n) && !io_n);
  c_sel: cover property ($fell(busy_n) && !sel_n);
endmodule
`default_nettype wire

// *** testbench/tb_disk_host_adapter_port.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_disk_host_adapter_port;
  logic        clk_i = 1'b0;                  // 200 MHz
  logic        resetn_i = 1'b0;
  logic        slave_clr_n = 1'b1;            // system slave clear
  logic        pstval_n = 1'b1, sout = 1'b0, sinp = 1'b0, pwr_n = 1'b1, pdbin = 1'b0;
  logic [7:0]  addr = 8'h00, dout = 8'h00, din, c_wd = 8'h00, c_rdata;
  logic        din_oe, c_wr = 1'b0, c_rd = 1'b0, rd_d = 1'b0;
  logic [1:0]  c_addr = 2'h0;
  logic [15:0] exp_q[$];                      // {mask, expected}
  logic [31:0] seed = 32'h000094f7;
  int          err_total = 0, samples_checked = 0, oe_cnt = 0;
  always #2.5 clk_i = ~clk_i;
  dhap_if cbus_if();
  dhap_adapter i_dhap_adapter (.clk_i(clk_i), .resetn_i(resetn_i), .slave_clr_n_i(slave_clr_n),
    .pstval_n_i(pstval_n), .sout_i(sout), .sinp_i(sinp), .pwr_n_i(pwr_n), .pdbin_i(pdbin),
    .addr_i(addr), .dout_i(dout), .din_o(din), .din_oe_o(din_oe), .cbus(cbus_if));
  dhap_controller i_dhap_controller (.clk_i(clk_i), .resetn_i(resetn_i), .addr_i(c_addr),
    .wdata_i(c_wd), .wr_i(c_wr), .rd_i(c_rd), .rdata_o(c_rdata), .cbus(cbus_if));
  dhap_asserts i_dhap_asserts (.clk_i(clk_i), .resetn_i(resetn_i), .sel_n(cbus_if.sel_n),
    .ack_n(cbus_if.ack_n), .busy_n(cbus_if.busy_n), .req_n(cbus_if.req_n), .io_n(cbus_if.io_n),
    .ad_oe(cbus_if.ad_oe), .ct_oe(cbus_if.ct_oe), .ad_do_n(cbus_if.ad_do_n), .data_n(cbus_if.data_n));
  // xorshift byte source
  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction
  // a zero mask marks a poll whose value is not judged
  task automatic check(input logic [7:0] got, input logic [7:0] m, input logic [7:0] e);
    if (m !== 8'h00) begin
      samples_checked++;
      if ((got & m) !== e) begin
        err_total++;
        $display("Error at %0t: got %h expected %h", $time, got & m, e);
      end
    end
  endtask
  // monitor: second clock of read drive, or cycle after a controller read
  always @(posedge clk_i) begin
    logic [15:0] n;
    oe_cnt <= (din_oe === 1'b1) ? oe_cnt + 1 : 0;
    rd_d <= c_rd;
    if (oe_cnt == 1 || rd_d) begin
      n = exp_q.pop_front();
      check((oe_cnt == 1) ? din : c_rdata, n[15:8], n[7:0]);
    end
  end
  // system port cycle; pins are synced, so the strobe is held nine clocks
  task automatic s_op(input logic w, input logic [1:0] p, input logic [7:0] d, m, e, output logic [7:0] v);
    if (!w) exp_q.push_back({m, e});
    @(posedge clk_i);
    {addr, dout} <= {6'h00, p, d};
    {sout, sinp, pwr_n, pdbin, pstval_n} <= {w, !w, !w, !w, 1'b0};
    repeat (8) @(posedge clk_i);
    #1 v = din;
    @(posedge clk_i);
    {sout, sinp, pwr_n, pdbin, pstval_n} <= 5'b00101;
    repeat (4) @(posedge clk_i);
  endtask
  // controller register access, read data in the cycle after the strobe
  task automatic c_op(input logic w, input logic [1:0] a, input logic [7:0] d, m, e, output logic [7:0] v);
    if (!w) exp_q.push_back({m, e});
    @(posedge clk_i);
    {c_addr, c_wd, c_wr, c_rd} <= {a, d, w, !w};
    @(posedge clk_i);
    {c_wr, c_rd} <= 2'b00;
    #1 v = c_rdata;
    @(posedge clk_i);
  endtask
  // bounded poll of a status bit on either end
  task automatic poll(input logic host, input int b);
    logic [7:0] v;
    for (int i = 0; i < 60; i++) begin
      if (host) s_op(1'b0, dhap_pkg::PORT_STAT, 8'h00, 8'h00, 8'h00, v);
      else c_op(1'b0, dhap_pkg::CREG_STAT, 8'h00, 8'h00, 8'h00, v);
      if (v[b] === 1'b1) break;
    end
  endtask
  // one byte through a phase; direction follows the phase code
  task automatic xfer(input logic [7:0] b, input logic last, input logic [1:0] ph);
    logic [7:0] v;
    logic       out;
    out = (ph == dhap_pkg::PH_CMD) || (ph == dhap_pkg::PH_DATA_OUT);
    c_op(1'b1, dhap_pkg::CREG_CMD, {5'h00, last, ph}, 8'h00, 8'h00, v);
    c_op(1'b1, dhap_pkg::CREG_DATA, b, 8'h00, 8'h00, v);
    poll(1'b1, dhap_pkg::STAT_REQ_BIT);
    s_op(1'b0, dhap_pkg::PORT_STAT, 8'h00, 8'hbf, {2'b10, last, ph[1], 4'hb}, v);
    s_op(out, dhap_pkg::PORT_DATA, b, out ? 8'h00 : 8'hff, out ? 8'h00 : b, v);
    poll(1'b0, 2);
    if (out) c_op(1'b0, dhap_pkg::CREG_DATA, 8'h00, 8'hff, b, v);
  endtask
  task automatic complete_run;
    if (err_total == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // main sequence
  initial begin
    logic [7:0] v;
    int         lens [6];
    logic [1:0] phs [6];
    lens = '{dhap_pkg::CDB_SHORT_LEN, dhap_pkg::SYNDROME_LEN, dhap_pkg::CDB_LONG_LEN, dhap_pkg::SENSE_LEN, 3, 1};
    phs = '{dhap_pkg::PH_CMD, dhap_pkg::PH_DATA_IN, dhap_pkg::PH_CMD, dhap_pkg::PH_DATA_IN,
            dhap_pkg::PH_DATA_OUT, dhap_pkg::PH_STATUS};
    repeat (16) @(posedge clk_i);
    resetn_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    // select value sent to unmapped and read-only ports must not select
    s_op(1'b1, 2'h3, 8'h40, 8'h00, 8'h00, v);
    s_op(1'b1, dhap_pkg::PORT_STAT, 8'h40, 8'h00, 8'h00, v);
    s_op(1'b0, dhap_pkg::PORT_STAT, 8'h00, 8'h0f, 8'h03, v);
    s_op(1'b1, dhap_pkg::PORT_CTRL, 8'h40, 8'h00, 8'h00, v);
    poll(1'b1, dhap_pkg::STAT_BUSY_BIT);
    s_op(1'b0, dhap_pkg::PORT_STAT, 8'h00, 8'h0f, 8'h0b, v);
    s_op(1'b1, dhap_pkg::PORT_CTRL, 8'h02, 8'h00, 8'h00, v);
    // descriptors (byte 0 class and opcode), replies, outbound data, status
    for (int j = 0; j < 6; j++)
      for (int i = 0; i < lens[j]; i++) xfer(rnd(), i == lens[j] - 1, phs[j]);
    // slave clear while select is asserted drops it
    s_op(1'b1, dhap_pkg::PORT_CTRL, 8'h40, 8'h00, 8'h00, v);
    slave_clr_n <= 1'b0;
    repeat (6) @(posedge clk_i);
    slave_clr_n <= 1'b1;
    repeat (2) @(posedge clk_i);
    check({6'h00, cbus_if.sel_n, cbus_if.ack_n}, 8'h03, 8'h03);
    complete_run();
  end
  // watchdog well past the expected run length
  initial begin
    repeat (40000) @(posedge clk_i);
    err_total++;
    complete_run();
  end
endmodule
`default_nettype wire
